// ### src/icao_cfg.svh
// Constants for the integer and conversion ALU operation group.
// Function
// - Opcode 53 selects integer subtract and writes the difference to the destination.
// - Integer subtract yields second source minus first source, the same for signed or unsigned.
// - Borrow-out writes 1 when the second source exceeds the first as unsigned, else 0.
// - Opcode 83 selects the unsigned borrow-out operation.
// - Opcode 17 writes the float integer part of the first source, truncated toward zero.
// - Byte-to-float shifts the first source by 0, 8, 16 or 24, masks with FF, converts to float.
// - Opcodes 164 to 167 select byte-to-float of byte 0 to 3.
// - Opcode 156 converts the first source as an unsigned 32-bit integer to float.
`ifndef ICAO_CFG_SVH
`define ICAO_CFG_SVH
`define ICAO_OP_XOR 11'h032
`define ICAO_OP_SUB 11'h035
`define ICAO_OP_BORROW 11'h053
`define ICAO_OP_TRUNC 11'h011
`define ICAO_OP_UTOF 11'h09C
`define ICAO_OP_BYTE0 11'h0A4
`define ICAO_OP_BYTE1 11'h0A5
`define ICAO_OP_BYTE2 11'h0A6
`define ICAO_OP_BYTE3 11'h0A7
`define ICAO_BYTE_MASK 32'h0000_00FF
`define ICAO_BYTE_SHIFT 5'h08
`define ICAO_BIAS 8'h7F
`define ICAO_MANT_W 8'h17
`define ICAO_ONE 32'h0000_0001
`endif

// ### src/icao_pkg.sv
// Types for the integer and conversion ALU operation group.
package icao_pkg;
  typedef logic [10:0] icao_op_t;
  typedef struct packed {
    logic valid;
    logic [31:0] result;
    logic bad_op;
  } icao_state_s;
endpackage

// ### src/icao_alu.sv
// Integer subtract, borrow, truncate, byte and unsigned to float, and xor unit.
`timescale 1ns/10ps
`default_nettype none
`include "icao_cfg.svh"
module icao_alu (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic [10:0] operation_select_field,
  input wire logic [31:0] src0,
  input wire logic [31:0] src1,
  output logic res_valid,
  output logic [31:0] res_data,
  output logic res_bad_op
);
  ////////////////////////////////////////////////////////////////////////////
  // Unsigned to float, rounding to nearest even.
  function automatic logic [31:0] u2f(input logic [31:0] v);
    logic [31:0] n;
    logic [4:0] msb;
    logic [7:0] e;
    logic [24:0] m;
    logic g;
    logic s;
    n = 32'h0;
    msb = 5'h0;
    e = 8'h0;
    m = 25'h0;
    g = 1'b0;
    s = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        msb = 5'(i);
      end
    end
    if (v == 32'h0) begin
      u2f = 32'h0;
    end else begin
      n = v << (5'h1F - msb);
      m = {1'b0, n[31:8]};
      g = n[7];
      s = |n[6:0];
      if (g && (s || m[0])) begin
        m = m + 25'h1;
      end
      e = `ICAO_BIAS + {3'h0, msb};
      if (m[24]) begin
        e = e + 8'h1;
        m = m >> 1;
      end
      u2f = {1'b0, e, m[22:0]};
    end
  endfunction

  // Float truncate toward zero.
  function automatic logic [31:0] ftrunc(input logic [31:0] f);
    logic [7:0] e;
    logic [22:0] keep;
    e = f[30:23];
    keep = 23'h0;
    if (e < `ICAO_BIAS) begin
      ftrunc = {f[31], 31'h0};
    end else if (e >= 8'(`ICAO_BIAS + `ICAO_MANT_W)) begin
      ftrunc = f;
    end else begin
      keep = 23'h7F_FFFF << (8'(`ICAO_BIAS + `ICAO_MANT_W) - e);
      ftrunc = {f[31:23], f[22:0] & keep};
    end
  endfunction

  // True for every opcode that this unit decodes; anything else is flagged bad.
  function automatic logic in_group(input logic [10:0] op);
    in_group = (op == `ICAO_OP_XOR) || (op == `ICAO_OP_SUB) || (op == `ICAO_OP_BORROW) ||
      (op == `ICAO_OP_TRUNC) || (op == `ICAO_OP_UTOF) || (op == `ICAO_OP_BYTE0) ||
      (op == `ICAO_OP_BYTE1) || (op == `ICAO_OP_BYTE2) || (op == `ICAO_OP_BYTE3);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  icao_pkg::icao_state_s st_q;
  icao_pkg::icao_state_s st_d;
  logic [1:0] bsel;
  logic [31:0] byte_v;

  always_comb begin
    st_d = st_q;
    st_d.valid = op_valid;
    st_d.bad_op = 1'b0;
    bsel = operation_select_field[1:0];
    byte_v = (src0 >> ({3'h0, bsel} * `ICAO_BYTE_SHIFT)) & `ICAO_BYTE_MASK;
    if (op_valid) begin
      case (operation_select_field)
        `ICAO_OP_SUB: st_d.result = src1 - src0;
        `ICAO_OP_BORROW: st_d.result = (src1 > src0) ? `ICAO_ONE : 32'h0;
        `ICAO_OP_TRUNC: st_d.result = ftrunc(src0);
        `ICAO_OP_UTOF: st_d.result = u2f(src0);
        `ICAO_OP_BYTE0, `ICAO_OP_BYTE1, `ICAO_OP_BYTE2, `ICAO_OP_BYTE3: begin
          st_d.result = u2f(byte_v);
        end
        `ICAO_OP_XOR: st_d.result = src0 ^ src1;
        default: begin
          st_d.result = 32'h0;
          st_d.bad_op = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign res_valid = st_q.valid;
  assign res_data = st_q.result;
  assign res_bad_op = st_q.bad_op;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_sub;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_SUB |=> res_data == $past(src1) - $past(src0);
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");
  property p_sub_wrap;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_SUB && src0 == src1 + 32'h1
      |=> res_data == 32'hFFFF_FFFF;
  endproperty
  a_sub_wrap: assert property (p_sub_wrap) else $error("subtract wrap wrong");
  property p_borrow;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_BORROW
      |=> res_data == {31'h0, $past(src1) > $past(src0)};
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow wrong");
  property p_borrow_dec;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_BORROW |=> !res_bad_op && res_data[31:1] == 31'h0;
  endproperty
  a_borrow_dec: assert property (p_borrow_dec) else $error("borrow decode wrong");
  property p_trunc;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_TRUNC && src0 == 32'h3FC0_0000
      |=> res_data == 32'h3F80_0000;
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncate wrong");
  property p_byte3;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_BYTE3 && src0 == 32'h0100_0000
      |=> res_data == 32'h3F80_0000;
  endproperty
  a_byte3: assert property (p_byte3) else $error("byte 3 convert wrong");
  property p_byte1;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_BYTE1 |=> res_data == u2f({24'h0, $past(src0[15:8])});
  endproperty
  a_byte1: assert property (p_byte1) else $error("byte 1 convert wrong");
  property p_utof;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_UTOF && src0 == 32'h8000_0000
      |=> res_data == 32'h4F00_0000;
  endproperty
  a_utof: assert property (p_utof) else $error("unsigned to float wrong");
  property p_xor;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_XOR |=> res_data == ($past(src0) ^ $past(src1));
  endproperty
  a_xor: assert property (p_xor) else $error("xor wrong");
  property p_dec_hex;
    @(posedge clk) disable iff (!rst_n)
      op_valid && (operation_select_field == 11'h0C9) |=> res_bad_op;
  endproperty
  a_dec_hex: assert property (p_dec_hex) else $error("misprinted opcode accepted");
  property p_order;
    @(posedge clk) disable iff (!rst_n) res_valid == $past(op_valid);
  endproperty
  a_order: assert property (p_order) else $error("result timing wrong");
  property p_bad_val;
    @(posedge clk) disable iff (!rst_n)
      op_valid && !in_group(operation_select_field)
      |=> res_valid && res_bad_op && res_data == 32'h0;
  endproperty
  a_bad_val: assert property (p_bad_val) else $error("unknown opcode not flagged");
  property p_good_op;
    @(posedge clk) disable iff (!rst_n)
      op_valid && in_group(operation_select_field) |=> !res_bad_op;
  endproperty
  a_good_op: assert property (p_good_op) else $error("group opcode flagged bad");
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !op_valid |=> !res_bad_op && res_data == $past(res_data);
  endproperty
  a_hold: assert property (p_hold) else $error("result not held while idle");
  property p_byte0;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_BYTE0 && src0[7:0] == 8'hAB
      |=> res_data == 32'h432B_0000;
  endproperty
  a_byte0: assert property (p_byte0) else $error("byte 0 convert wrong");
  property p_byte2;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_BYTE2 && src0[23:16] == 8'h34
      |=> res_data == 32'h4250_0000;
  endproperty
  a_byte2: assert property (p_byte2) else $error("byte 2 convert wrong");
  property p_trunc_small;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_TRUNC && src0[30:23] < `ICAO_BIAS
      |=> res_data == {$past(src0[31]), 31'h0};
  endproperty
  a_trunc_small: assert property (p_trunc_small) else $error("truncate below one wrong");
  property p_utof_zero;
    @(posedge clk) disable iff (!rst_n)
      op_valid && operation_select_field == `ICAO_OP_UTOF && src0 == 32'h0
      |=> res_data == 32'h0;
  endproperty
  a_utof_zero: assert property (p_utof_zero) else $error("unsigned zero convert wrong");
  c_sub: cover property (@(posedge clk) op_valid && operation_select_field == `ICAO_OP_SUB);
  c_byte: cover property (@(posedge clk) op_valid && operation_select_field == `ICAO_OP_BYTE2);
  c_b2b: cover property (@(posedge clk) op_valid ##1 op_valid);
  c_borrow: cover property (@(posedge clk) op_valid && operation_select_field == `ICAO_OP_BORROW);
  c_bad: cover property (@(posedge clk) res_valid && res_bad_op);
endmodule // icao_alu
`default_nettype wire

// ### sim/icao_issue_model.sv
// Issue-side model that presents one operation per clock to the unit.
`timescale 1ns/10ps
`default_nettype none
module icao_issue_model (
  input wire logic clk,
  output logic op_valid,
  output logic [10:0] op_code,
  output logic [31:0] src0,
  output logic [31:0] src1
);
  initial begin
    op_valid = 1'b0;
    op_code = 11'h000;
    src0 = 32'h0000_0000;
    src1 = 32'h0000_0000;
  end
  task automatic issue(input logic [10:0] op, input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    #1;
    op_valid = 1'b1;
    op_code = op;
    src0 = a;
    src1 = b;
  endtask
  // Released operands flip so a stale value cannot pass for a live one.
  task automatic idle();
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    src0 = ~src0;
    src1 = ~src1;
  endtask
endmodule // icao_issue_model
`default_nettype wire

// ### sim/icao_alu_tb_top.sv
// Self-checking bench for the integer and conversion operation unit.
`timescale 1ns/10ps
`default_nettype none
`include "icao_cfg.svh"
module icao_alu_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid, res_valid, res_bad_op;
  logic [10:0] op_code;
  logic [31:0] src0, src1, res_data;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  icao_issue_model icao_issue_model_i (.clk(clk), .op_valid(op_valid), .op_code(op_code),
    .src0(src0), .src1(src1));
  icao_alu icao_alu_i (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
    .operation_select_field(op_code), .src0(src0), .src1(src1), .res_valid(res_valid),
    .res_data(res_data), .res_bad_op(res_bad_op));
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  // Result is due right after the edge that takes the operands.
  task automatic run(input logic [10:0] op, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] exp, input logic bad);
    icao_issue_model_i.issue(op, a, b);
    icao_issue_model_i.idle();
    chk("res_valid", 32'h1, {31'h0, res_valid});
    chk("res_bad_op", {31'h0, bad}, {31'h0, res_bad_op});
    chk("res_data", exp, res_data);
  endtask
  task automatic sc_integer();
    run(`ICAO_OP_SUB, 32'h0000_0001, 32'h0000_0005, 32'h0000_0004, 1'b0);
    run(`ICAO_OP_SUB, 32'h0000_0001, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
    run(`ICAO_OP_BORROW, 32'h0000_0001, 32'h8000_0000, 32'h0000_0001, 1'b0);
    run(`ICAO_OP_BORROW, 32'h8000_0000, 32'h8000_0000, 32'h0000_0000, 1'b0);
    run(`ICAO_OP_BORROW, 32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0000, 1'b0);
    run(`ICAO_OP_XOR, 32'hF0F0_A5A5, 32'h0FF0_FFFF, 32'hFF00_5A5A, 1'b0);
  endtask
  task automatic sc_convert();
    run(`ICAO_OP_TRUNC, 32'h4020_0000, 32'h0, 32'h4000_0000, 1'b0);
    run(`ICAO_OP_TRUNC, 32'hBFE0_0000, 32'h0, 32'hBF80_0000, 1'b0);
    run(`ICAO_OP_TRUNC, 32'h3FC0_0000, 32'h0, 32'h3F80_0000, 1'b0);
    run(`ICAO_OP_TRUNC, 32'hBF00_0000, 32'h0, 32'h8000_0000, 1'b0);
    run(`ICAO_OP_BYTE3, 32'h0100_0000, 32'h0, 32'h3F80_0000, 1'b0);
    run(`ICAO_OP_UTOF, 32'h8000_0000, 32'h0, 32'h4F00_0000, 1'b0);
    run(`ICAO_OP_UTOF, 32'h0000_0000, 32'h0, 32'h0000_0000, 1'b0);
    run(`ICAO_OP_BYTE0, 32'h1234_5678, 32'h0, 32'h42F0_0000, 1'b0);
    run(`ICAO_OP_BYTE1, 32'h1234_5678, 32'h0, 32'h42AC_0000, 1'b0);
    run(`ICAO_OP_BYTE2, 32'h1234_5678, 32'h0, 32'h4250_0000, 1'b0);
    run(`ICAO_OP_BYTE3, 32'h1234_5678, 32'h0, 32'h4190_0000, 1'b0);
    run(`ICAO_OP_BYTE0, 32'hFFFF_FFAB, 32'h0, 32'h432B_0000, 1'b0);
    run(`ICAO_OP_UTOF, 32'hFFFF_FFFF, 32'h0, 32'h4F80_0000, 1'b0);
  endtask
  // Outputs clear at once on a mid-run reset and stay clear after release.
  task automatic sc_reset();
    icao_issue_model_i.idle();
    rst_n = 1'b0;
    #1;
    chk("res_data reset", 32'h0, res_data);
    chk("res_valid reset", 32'h0, {31'h0, res_valid});
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    chk("res_data after reset", 32'h0, res_data);
  endtask
  // Two operations back to back come out in issue order.
  task automatic sc_order();
    run(11'h0C9, 32'h1234_5678, 32'h0, 32'h0000_0000, 1'b1);
    icao_issue_model_i.issue(`ICAO_OP_SUB, 32'h0000_0003, 32'h0000_000A);
    icao_issue_model_i.issue(`ICAO_OP_XOR, 32'h0000_00F0, 32'h0000_000F);
    chk("res_data first", 32'h0000_0007, res_data);
    icao_issue_model_i.idle();
    chk("res_valid second", 32'h1, {31'h0, res_valid});
    chk("res_data second", 32'h0000_00FF, res_data);
    @(posedge clk);
    #1;
    chk("res_valid idle", 32'h0, {31'h0, res_valid});
    chk("res_data held", 32'h0000_00FF, res_data);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 1000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    sc_integer();
    sc_convert();
    sc_reset();
    sc_order();
    close_out();
  end
endmodule // icao_alu_tb_top
`default_nettype wire
